// >>> pkg/dac_update_defines.vh
// Constants for the analog output update and digital I/O control block
`ifndef DAC_UPDATE_DEFINES_VH
`define DAC_UPDATE_DEFINES_VH
// Host I/O offsets (byte addresses within the I/O window)
`define OFS_CH_BASE 5'h00
`define OFS_CH_LAST 5'h0b
`define OFS_SIM_UPDATE 5'h08
`define OFS_AUTO_UPDATE 5'h0a
`define OFS_GO_AUTO 5'h02
`define OFS_REF_NORMAL 5'h0c
`define OFS_SIM_MODE 5'h0e
`define OFS_DIO_DATA 5'h10
`define OFS_DIO_DIR 5'h12
// Reset values
`define RST_CODE 16'h0000
`define RST_DIR 2'h0
`endif

// >>> rtl/preload_mem.v
// Per-channel preload storage with byte writes and registered read
`timescale 1ns/1ps
module preload_mem #(
  parameter CHANNELS = 6,
  parameter AW = 3
) (
  input wire i_clk, // Card clock
  input wire [AW-1:0] i_waddr, // Channel written
  input wire [1:0] i_wbe, // Byte enables, bit 1 high byte
  input wire [15:0] i_wdata, // Write data
  input wire [AW-1:0] i_raddr, // Channel read
  output reg [15:0] o_rdata // Registered read data
);
  reg [15:0] mem [0:CHANNELS-1];

  // Byte-lane writes; registered read shows the bytes written in the same cycle
  always @(posedge i_clk) begin
    if (i_wbe[0]) begin
      mem[i_waddr][7:0] <= i_wdata[7:0];
    end
    if (i_wbe[1]) begin
      mem[i_waddr][15:8] <= i_wdata[15:8];
    end
    o_rdata <= mem[i_raddr];
    // Write-through merge, so a load right after a write gets the whole new word
    if (i_raddr == i_waddr) begin
      if (i_wbe[0]) begin
        o_rdata[7:0] <= i_wdata[7:0];
      end
      if (i_wbe[1]) begin
        o_rdata[15:8] <= i_wdata[15:8];
      end
    end
  end
endmodule

// >>> rtl/dac_update_dio_control.v
// Analog output double-buffer update control and 16-line digital I/O
`timescale 1ns/1ps
`include "dac_update_defines.vh"
module dac_update_dio_control #(
  parameter CHANNELS = 6,
  parameter AW = 3
) (
  input wire i_clk, // Card clock, 125 MHz
  input wire i_rst, // Async reset, active high
  input wire i_wr, // Host write strobe, one cycle
  input wire i_rd, // Host read strobe, one cycle
  input wire [4:0] i_addr, // Host byte offset
  input wire [1:0] i_be, // Byte enables, bit 1 upper byte
  input wire [15:0] i_wdata, // Host write data
  output reg [15:0] o_rdata, // Host read data
  output reg o_rvalid, // Read data valid pulse
  output reg o_conv_load, // Word load strobe to converter
  output reg [AW-1:0] o_conv_ch, // Channel being loaded
  output reg [15:0] o_conv_data, // Whole word to converter buffer
  output reg [CHANNELS-1:0] o_active_upd, // Active copy strobes per channel
  output reg o_ref_normal, // High once reference is normal
  output reg o_sim_mode, // High in simultaneous update mode
  input wire [15:0] i_dio, // Digital line levels
  output reg [15:0] o_dio, // Digital line drive values
  output reg [15:0] o_dio_oe // Drive enables, high drives
);
  // Decoded channel from a byte offset
  function [AW-1:0] chan_of;
    input [4:0] a;
    begin
      chan_of = a[AW:1];
    end
  endfunction

  wire ch_hit = (i_addr <= `OFS_CH_LAST) && (i_addr[0] == 1'b0);
  wire wr_ch = i_wr && ch_hit;
  wire [AW-1:0] wr_chan = chan_of(i_addr);
  wire [1:0] mem_be = wr_ch ? i_be : 2'h0;
  wire [15:0] mem_q;
  reg sim_reg;
  reg ref_reg;
  reg [1:0] dir_reg;
  reg [15:0] dout_reg;
  reg load_pend_reg;
  reg [AW-1:0] load_ch_reg;
  reg all_pend_reg;
  reg [AW-1:0] scan_reg;
  reg scanning_reg;
  reg [AW-1:0] rd_ch_next;
  reg [CHANNELS-1:0] upd_next;
  integer k;

  // Preload storage; the update path re-reads it so partial writes never leak
  preload_mem #(.CHANNELS(CHANNELS), .AW(AW)) u_mem (
    .i_clk(i_clk),
    .i_waddr(wr_chan),
    .i_wbe(mem_be),
    .i_wdata(i_wdata),
    .i_raddr(rd_ch_next),
    .o_rdata(mem_q)
  );

  // Memory read address runs one channel ahead of the converter word
  // Idle: the channel being written, so its load sees the merged word
  always @* begin
    rd_ch_next = wr_chan;
    if (scanning_reg) begin
      if (scan_reg != CHANNELS - 1) begin
        rd_ch_next = scan_reg + 1'b1;
      end
    end else if (all_pend_reg) begin
      rd_ch_next = {AW{1'b0}};
    end
  end

  // Mode, reference and command decoding
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sim_reg <= 1'b1;
      ref_reg <= 1'b0;
      all_pend_reg <= 1'b0;
    end else begin
      all_pend_reg <= 1'b0;
      if (i_rd && sim_reg && i_addr == `OFS_SIM_UPDATE) begin
        all_pend_reg <= 1'b1;
      end
      if (i_rd && i_addr == `OFS_AUTO_UPDATE) begin
        all_pend_reg <= 1'b1;
        sim_reg <= 1'b0;
      end
      if (i_rd && sim_reg && i_addr == `OFS_GO_AUTO) begin
        sim_reg <= 1'b0;
      end
      if (i_wr && i_addr == `OFS_SIM_MODE) begin
        sim_reg <= 1'b1;
      end
      if (i_wr && i_addr == `OFS_REF_NORMAL) begin
        ref_reg <= i_wdata[0];
      end
    end
  end

  // Converter word loads: single channel in auto mode, scan for all
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      load_pend_reg <= 1'b0;
      load_ch_reg <= {AW{1'b0}};
      scan_reg <= {AW{1'b0}};
      scanning_reg <= 1'b0;
    end else begin
      load_pend_reg <= 1'b0;
      // Only a high byte write triggers; low byte waits
      if (wr_ch && i_be[1] && !sim_reg && !scanning_reg) begin
        load_pend_reg <= 1'b1;
        load_ch_reg <= wr_chan;
      end
      if (all_pend_reg && !scanning_reg) begin
        scanning_reg <= 1'b1;
        scan_reg <= {AW{1'b0}};
      end else if (scanning_reg) begin
        if (scan_reg == CHANNELS - 1) begin
          scanning_reg <= 1'b0;
        end else begin
          scan_reg <= scan_reg + 1'b1;
        end
      end
    end
  end

  // Active strobes: one channel, or all at the end of the scan
  always @* begin
    upd_next = {CHANNELS{1'b0}};
    if (load_pend_reg) begin
      for (k = 0; k < CHANNELS; k = k + 1) begin
        if (load_ch_reg == k) begin
          upd_next[k] = 1'b1;
        end
      end
    end
    if (scanning_reg && scan_reg == CHANNELS - 1) begin
      upd_next = {CHANNELS{1'b1}};
    end
  end

  // Converter outputs, all from flip-flops; zero word at reset
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_conv_load <= 1'b0;
      o_conv_ch <= {AW{1'b0}};
      o_conv_data <= `RST_CODE;
      o_active_upd <= {CHANNELS{1'b0}};
      o_ref_normal <= 1'b0;
      o_sim_mode <= 1'b1;
    end else begin
      o_conv_load <= load_pend_reg | scanning_reg;
      o_conv_ch <= scanning_reg ? scan_reg : load_ch_reg;
      o_conv_data <= mem_q;
      o_active_upd <= upd_next;
      o_ref_normal <= ref_reg;
      o_sim_mode <= sim_reg;
    end
  end

  // Digital I/O ports; a port drives only when set to output
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dir_reg <= `RST_DIR;
      dout_reg <= 16'h0000;
      o_dio <= 16'h0000;
      o_dio_oe <= 16'h0000;
      o_rdata <= 16'h0000;
      o_rvalid <= 1'b0;
    end else begin
      if (i_wr && i_addr == `OFS_DIO_DIR) begin
        dir_reg <= i_wdata[1:0];
      end
      if (i_wr && i_addr == `OFS_DIO_DATA) begin
        if (i_be[0]) begin
          dout_reg[7:0] <= i_wdata[7:0];
        end
        if (i_be[1]) begin
          dout_reg[15:8] <= i_wdata[15:8];
        end
      end
      o_dio <= dout_reg;
      o_dio_oe <= {{8{dir_reg[1]}}, {8{dir_reg[0]}}};
      o_rvalid <= i_rd;
      if (i_rd && i_addr == `OFS_DIO_DATA) begin
        o_rdata <= i_dio;
      end else if (i_rd && i_addr == `OFS_DIO_DIR) begin
        o_rdata <= {14'h0000, dir_reg};
      end else begin
        o_rdata <= 16'h0000;
      end
    end
  end
endmodule

// >>> tb/dac_update_checker.sv
// Assertions for the converter update and digital I/O block
`timescale 1ns/1ps
`include "dac_update_defines.vh"
module dac_update_checker #(parameter CHANNELS = 6, parameter AW = 3) (
  input wire i_clk, input wire i_rst, input wire i_wr, input wire i_rd,
  input wire [4:0] i_addr, input wire [1:0] i_be, input wire [15:0] i_wdata,
  input wire [15:0] o_rdata, input wire o_rvalid, input wire o_conv_load,
  input wire [AW-1:0] o_conv_ch, input wire [15:0] o_conv_data,
  input wire [CHANNELS-1:0] o_active_upd, input wire o_ref_normal,
  input wire o_sim_mode, input wire [15:0] i_dio, input wire [15:0] o_dio,
  input wire [15:0] o_dio_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Channel writes only at even offsets; commands decoded apart
  wire ch_wr = i_wr && !i_addr[0] && i_addr <= `OFS_CH_LAST;
  wire auto_wr = ch_wr && !o_sim_mode;
  wire ref_cmd = i_wr && i_addr == `OFS_REF_NORMAL && i_wdata[0];
  // All-channel scan: channel 0 first, all active strobes at the end
  sequence scan_s;
    ##3 (o_conv_load && o_conv_ch == 0) ##5 (&o_active_upd);
  endsequence
  sim_update_a: assert property (o_sim_mode && i_rd && i_addr == `OFS_SIM_UPDATE |-> scan_s)
    else $error("all-channel update missing");
  upd_auto_a: assert property (o_sim_mode && i_rd && i_addr == `OFS_AUTO_UPDATE |-> scan_s ##1 !o_sim_mode)
    else $error("update then auto mode missing");
  go_auto_a: assert property (o_sim_mode && i_rd && i_addr == `OFS_GO_AUTO |-> ##2 (!o_sim_mode && o_active_upd == 0)[*6])
    else $error("mode change updated outputs");
  auto_load_a: assert property (auto_wr && i_be[1] |-> ##2 (o_conv_load && o_conv_ch == $past(i_addr[3:1], 2) && o_active_upd[o_conv_ch]))
    else $error("high byte did not update channel");
  word_data_a: assert property (auto_wr && i_be == 2'h3 |-> ##2 o_conv_data == $past(i_wdata, 2))
    else $error("converter word differs");
  low_hold_a: assert property (auto_wr && i_be == 2'h1 |-> ##2 !o_conv_load)
    else $error("low byte alone loaded");
  sim_quiet_a: assert property (o_sim_mode && ch_wr |-> ##2 !o_conv_load)
    else $error("write loaded in simultaneous mode");
  ref_cause_a: assert property ($rose(o_ref_normal) |-> $past(ref_cmd) || $past(ref_cmd, 2))
    else $error("reference left restricted state uncommanded");
  byte_dir_a: assert property ((o_dio_oe[7:0] == 0 || &o_dio_oe[7:0]) && (o_dio_oe[15:8] == 0 || &o_dio_oe[15:8]))
    else $error("direction not byte wide");
endmodule
bind dac_update_dio_control dac_update_checker #(.CHANNELS(CHANNELS), .AW(AW)) dac_update_checker_inst (.*);

// >>> tb/conv_model.sv
// Converter model: buffer and active register per channel
`timescale 1ns/1ps
module conv_model (
  input wire i_clk, // Card clock
  input wire i_load, // Word load strobe
  input wire [2:0] i_ch, // Channel loaded
  input wire [15:0] i_data, // Word loaded
  input wire [5:0] i_upd, // Active copy strobes
  output logic [15:0] o_active [6] // Active values
);
  logic [15:0] hold_reg [6];
  // Power-on zero output
  initial for (int n = 0; n < 6; n++) begin
    hold_reg[n] = 16'h0000;
    o_active[n] = 16'h0000;
  end
  // A same-cycle copy takes the word being loaded
  always @(posedge i_clk) begin
    if (i_load) hold_reg[i_ch] <= i_data;
    for (int n = 0; n < 6; n++)
      if (i_upd[n]) o_active[n] <= (i_load && i_ch == n) ? i_data : hold_reg[n];
  end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the converter update and digital I/O block
`timescale 1ns/1ps
`include "dac_update_defines.vh"
module testbench;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, o_rvalid, o_conv_load;
  logic o_ref_normal, o_sim_mode;
  logic [4:0] i_addr = 5'h00;
  logic [1:0] i_be = 2'h0;
  logic [15:0] i_wdata = 16'h0000, ext = 16'hffff, rd_val, o_rdata, o_conv_data, o_dio, o_dio_oe;
  logic rv_val;
  logic [2:0] o_conv_ch;
  logic [5:0] o_active_upd;
  logic [15:0] act [6];
  logic [38:0] rows [5];
  int err_count = 0, check_count = 0;
  // Undriven lines take the external levels in ext, all high until ext is set to 16'h3cc3
  wire [15:0] dio_line = (o_dio & o_dio_oe) | (ext & ~o_dio_oe);
  always #4 i_clk = ~i_clk;
  dac_update_dio_control dac_update_dio_control_inst (.i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr),
    .i_rd(i_rd), .i_addr(i_addr), .i_be(i_be), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_conv_load(o_conv_load), .o_conv_ch(o_conv_ch),
    .o_conv_data(o_conv_data), .o_active_upd(o_active_upd), .o_ref_normal(o_ref_normal),
    .o_sim_mode(o_sim_mode), .i_dio(dio_line), .o_dio(o_dio), .o_dio_oe(o_dio_oe));
  conv_model conv_model_inst (.i_clk(i_clk), .i_load(o_conv_load), .i_ch(o_conv_ch),
    .i_data(o_conv_data), .i_upd(o_active_upd), .o_active(act));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Each access is followed by 8 idle cycles, covering scan spacing
  task wr(input logic [4:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_be <= be;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    repeat (8) @(posedge i_clk);
    #1;
  endtask
  task rd(input logic [4:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
    rv_val = o_rvalid;
    repeat (8) @(posedge i_clk);
    #1;
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge i_clk);
    err_count++;
    tally_and_finish;
  end
  initial begin
    // Auto mode rows: offset, enables, data, expected active value
    rows = '{{5'h02, 2'h3, 16'ha5a5, 16'ha5a5}, {5'h04, 2'h1, 16'h0033, 16'h1002},
      {5'h04, 2'h2, 16'h4400, 16'h4433}, {5'h06, 2'h2, 16'hbe00, 16'hbe03},
      {5'h0a, 2'h3, 16'h5555, 16'h5555}};
    repeat (10) @(posedge i_clk);
    #1 chk(o_dio_oe, 16'h0000);
    chk({15'h0, o_sim_mode}, 16'h0001);
    @(posedge i_clk) i_rst <= 1'b0;
    #1 chk({15'h0, o_ref_normal}, 16'h0000);
    chk(o_conv_data, 16'h0000);
    for (int n = 0; n < 6; n++) wr(5'(2 * n), 2'h3, 16'h1000 + 16'(n));
    chk(act[3], 16'h0000);
    rd(`OFS_SIM_UPDATE);
    for (int n = 0; n < 6; n++) chk(act[n], 16'h1000 + 16'(n));
    wr(`OFS_CH_BASE, 2'h3, 16'h2222);
    rd(`OFS_GO_AUTO);
    chk(act[0], 16'h1000);
    foreach (rows[r]) begin
      wr(rows[r][38:34], rows[r][33:32], rows[r][31:16]);
      chk(act[rows[r][37:35]], rows[r][15:0]);
    end
    wr(`OFS_SIM_MODE, 2'h3, 16'h0000);
    wr(5'h08, 2'h3, 16'h7777);
    chk(act[4], 16'h1004);
    rd(`OFS_AUTO_UPDATE);
    chk(act[4], 16'h7777);
    chk(act[0], 16'h2222);
    wr(5'h08, 2'h3, 16'h8888);
    chk(act[4], 16'h8888);
    wr(`OFS_REF_NORMAL, 2'h3, 16'h0001);
    chk({15'h0, o_ref_normal}, 16'h0001);
    wr(`OFS_DIO_DIR, 2'h3, 16'h0001);
    wr(`OFS_DIO_DATA, 2'h3, 16'h5aa5);
    ext = 16'h3cc3;
    rd(`OFS_DIO_DATA);
    chk(o_dio_oe, 16'h00ff);
    chk(rd_val, 16'h3ca5);
    chk({15'h0, rv_val}, 16'h0001);
    @(posedge i_clk) i_rst <= 1'b1;
    #1 chk(o_dio_oe, 16'h0000);
    chk({15'h0, o_sim_mode}, 16'h0001);
    tally_and_finish;
  end
endmodule
